// File: src/dts_pkg.sv
package dts_pkg;

    // ****************************************************************
    // Register offsets (byte addresses on the word bus)
    // ****************************************************************
    localparam logic [7:0] TRACE_CONTROL_OFF = 8'h22;
    localparam logic [7:0] MATCH_FLAG_OFF = 8'h27;
    localparam logic [7:0] DEBUG_CONTROL_OFF = 8'h20;
    localparam logic [7:0] DEBUG_STATUS_OFF = 8'h21;
    localparam logic [7:0] STATE3_CTRL_OFF = 8'h24;
    localparam logic [7:0] PAGE_SELECT_OFF = 8'h26;
    localparam logic [7:0] COMP_WINDOW_OFF = 8'h28;
    localparam logic [7:0] COMP_WINDOW_END = 8'h2F;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int TC_RSVD_BIT = 7;
    localparam int TC_SOURCE_BIT = 6;
    localparam int TC_RANGE_LSB = 4;
    localparam int TC_MODE_LSB = 2;
    localparam int TC_ALIGN_LSB = 0;
    localparam int DC_ARM_BIT = 7;
    localparam int DC_IMMEDIATE_TRIGGER_BIT = 6;
    localparam int DC_BRK_BIT = 4;
    localparam int CMP_ENABLE_BIT = 0;
    localparam int CMP_RANGE_BIT = 1;
    localparam logic [7:0] TRACE_CONTROL_RST = 8'h00;
    localparam logic [7:0] DEBUG_CONTROL_RST = 8'h00;
    localparam logic [3:0] STATE3_CTRL_RST = 4'h0;
    localparam logic [1:0] PAGE_MATCH_FLAGS = 2'h3;
    localparam logic [1:0] TRACE_COMPLETE_CYCLES = 2'h3;

    // ****************************************************************
    // Encodings
    // ****************************************************************
    typedef enum logic [2:0] {
        DTS_ST_DISARMED = 3'h0,
        DTS_ST_ONE = 3'h1,
        DTS_ST_TWO = 3'h2,
        DTS_ST_THREE = 3'h3,
        DTS_ST_FINAL = 3'h4
    } dts_state_t;

    typedef enum logic [1:0] {
        DTS_ALIGN_BEGIN = 2'h0,
        DTS_ALIGN_END = 2'h1,
        DTS_ALIGN_MID = 2'h2,
        DTS_ALIGN_RSVD = 2'h3
    } dts_align_t;

    typedef enum logic [1:0] {
        DTS_MODE_NORMAL = 2'h0,
        DTS_MODE_LOOP_SUPPRESS = 2'h1,
        DTS_MODE_DETAIL = 2'h2,
        DTS_MODE_RSVD = 2'h3
    } dts_mode_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } dts_wb_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
        logic valid;
        logic exec;
    } dts_core_bus_t;

endpackage : dts_pkg

// File: src/dts_comp_bank.sv
`timescale 1ns/100ps
// ********************************************************************
// Comparator register banks: four 8-byte windows, registered read data
// ********************************************************************
module dts_comp_bank #(
    parameter int CHANNELS = 4
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic wr_en,
    input wire logic [1:0] wr_chan,
    input wire logic [2:0] wr_byte,
    input wire logic [7:0] wr_data,
    input wire logic [1:0] rd_chan,
    input wire logic [2:0] rd_byte,
    output logic [7:0] rd_data_ff,
    output logic [CHANNELS*64-1:0] banks
);
    logic [7:0] mem_ff [CHANNELS][8];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int c = 0; c < CHANNELS; c++) begin
                for (int b = 0; b < 8; b++) begin
                    mem_ff[c][b] <= 8'h00;
                end
            end
            rd_data_ff <= 8'h00;
        end else begin
            if (wr_en) begin
                mem_ff[wr_chan][wr_byte] <= wr_data;
            end
            rd_data_ff <= mem_ff[rd_chan][rd_byte];
        end
    end

    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            for (int b = 0; b < 8; b++) begin
                banks[c*64+b*8 +: 8] = mem_ff[c][b];
            end
        end
    end
endmodule : dts_comp_bank

// File: src/dts_comparators.sv
`timescale 1ns/100ps
// ********************************************************************
// Address comparators with range pairing of channels 0 and 2
// ********************************************************************
module dts_comparators #(
    parameter int CHANNELS = 4
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [CHANNELS*64-1:0] banks,
    input wire dts_pkg::dts_core_bus_t core,
    output logic [3:0] match_ff,
    output logic [3:0] in_range_ff
);
    logic [3:0] hit;
    logic [3:0] en;
    logic range_mode;
    logic [3:0] raw;

    // Byte 0 control, bytes 1..2 address high/low
    function automatic logic [15:0] cmp_addr(input logic [63:0] b);
        cmp_addr = {b[15:8], b[23:16]};
    endfunction : cmp_addr

    always_comb begin
        for (int c = 0; c < 4; c++) begin
            en[c] = banks[c*64 + dts_pkg::CMP_ENABLE_BIT];
            hit[c] = core.valid && core.addr == cmp_addr(banks[c*64 +: 64]);
        end
    end

    assign range_mode = banks[dts_pkg::CMP_RANGE_BIT];
    // Range hit uses A as low bound and C as high bound
    wire range_hit = core.valid && core.addr >= cmp_addr(banks[0 +: 64])
        && core.addr <= cmp_addr(banks[128 +: 64]);

    always_comb begin
        raw = hit & en;
        if (range_mode) begin
            raw[0] = range_hit && en[0]; // R20
            raw[2] = 1'b0; // R20
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            match_ff <= 4'h0;
            in_range_ff <= 4'h0;
        end else begin
            match_ff <= raw;
            in_range_ff <= {2'b00, range_hit, range_hit};
        end
    end
endmodule : dts_comparators

// File: src/dts_trigger_sequencer.sv
// The Wishbone slave port was decided locally.
`timescale 1ns/100ps
// ********************************************************************
// Notes on behaviour
// R01: Final state is reported as code 100; 101, 110, 111 reserved.
// R02: Bits 7:6 writable only unsecured and disarmed; bits 5:0 when disarmed.
// R03: Software keeps trace control bit 7 cleared.
// R04: Source bit enables tracing; cannot be set while secured, tracing inhibited.
// R05: Range bits filter detail tracing; range comparators keep compare enable clear.
// R06: Mode bits pick normal, loop suppress or detail storage; loop suppress stores exactly as normal does, on core_tag_hit.
// R07: Alignment bits put the trigger at begin, end or middle.
// R08: State-3 codes 0010 to 0110 decode as listed.
// R09: State-3 codes 0111 to 1010 decode as listed.
// R10: Codes 1011 to 1101 decode as listed; 1110 and 1111 do nothing.
// R11: Lower channel wins; a match leading to final wins over all.
// R12: Match flags at 0x27 only when page select is 11; read only.
// R13: Match flags set per channel in session, cleared only by arming.
// R14: Each comparator bank is an 8-byte window.
// R15: Forced comparator match advances at once and sets flags.
// R16: Tagged matches act when the core reports a tag hit.
// R17: Immediate trigger goes final (begin, mid) or disarms (end).
// R18: Breakpoint request immediate at end alignment, else after tracing completes.
// R19: Only the highest priority coincident trigger acts.
// R20: Range mode: A and C together give match0, match2 suppressed.
// R21: Hardware disarm beats a simultaneous arm write.
// R22: Reserved state codes are never loaded.
// ********************************************************************
module dts_trigger_sequencer #(
    parameter int CHANNELS = 4
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o_ff,
    output logic wb_ack_o_ff,
    input wire logic secured,
    input wire logic [15:0] core_addr,
    input wire logic [15:0] core_data,
    input wire logic core_valid,
    input wire logic core_tag_hit,
    output logic [3:0] tag_req_ff,
    output logic trace_enable_ff,
    output logic trace_store_ff,
    output logic breakpoint_req_ff,
    output logic armed_ff
);
    // ****************************************************************
    // Bus decode
    // ****************************************************************
    dts_pkg::dts_core_bus_t core;
    assign core = '{addr: core_addr, data: core_data, valid: core_valid, exec: core_tag_hit};

    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o_ff;
    wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    wire [7:0] wdat = wb_dat_i[7:0];
    wire sel_tc = wb_adr_i == dts_pkg::TRACE_CONTROL_OFF;
    wire sel_dc = wb_adr_i == dts_pkg::DEBUG_CONTROL_OFF;
    wire sel_sr = wb_adr_i == dts_pkg::DEBUG_STATUS_OFF;
    wire sel_s3 = wb_adr_i == dts_pkg::STATE3_CTRL_OFF;
    wire sel_pg = wb_adr_i == dts_pkg::PAGE_SELECT_OFF;
    wire sel_mf = wb_adr_i == dts_pkg::MATCH_FLAG_OFF;
    wire sel_cmp = wb_adr_i >= dts_pkg::COMP_WINDOW_OFF && wb_adr_i <= dts_pkg::COMP_WINDOW_END;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] trace_control_ff;
    logic [7:0] nxt_trace_control;
    logic [3:0] next_state_code_ff;
    logic [1:0] comparator_page_select_ff;
    logic [3:0] match_flag_ff;
    logic [3:0] nxt_match_flag;
    logic breakpoint_enable_ff;
    dts_pkg::dts_state_t state_ff;
    dts_pkg::dts_state_t nxt_state;
    logic nxt_armed;
    logic pending_brk_ff;
    logic [1:0] complete_cnt_ff;
    logic [3:0] tagged_ff;

    wire [1:0] trace_range_select = trace_control_ff[dts_pkg::TC_RANGE_LSB +: 2];
    wire [1:0] trace_mode_select = trace_control_ff[dts_pkg::TC_MODE_LSB +: 2];
    wire [1:0] trigger_alignment = trace_control_ff[dts_pkg::TC_ALIGN_LSB +: 2];
    wire trace_source_enable = trace_control_ff[dts_pkg::TC_SOURCE_BIT];
    wire align_end = trigger_alignment == dts_pkg::DTS_ALIGN_END;

    // R02 R04: upper bits guarded by secure and arm, lower by arm only
    always_comb begin
        nxt_trace_control = trace_control_ff;
        if (bus_wr && sel_tc && !armed_ff) begin
            nxt_trace_control[5:0] = wdat[5:0]; // R02
            if (!secured) begin
                nxt_trace_control[7:6] = wdat[7:6]; // R02
            end
        end
        if (secured) begin
            nxt_trace_control[dts_pkg::TC_SOURCE_BIT] = 1'b0; // R04
        end
    end

    // ****************************************************************
    // Comparators and their register windows
    // ****************************************************************
    logic [CHANNELS*64-1:0] banks;
    logic [7:0] cmp_rd;
    logic [3:0] match;
    logic [3:0] in_range;

    dts_comp_bank #(.CHANNELS(CHANNELS)) u_bank (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .wr_en(bus_wr && sel_cmp && !armed_ff), // R14
        .wr_chan(comparator_page_select_ff),
        .wr_byte(wb_adr_i[2:0]),
        .wr_data(wdat),
        .rd_chan(comparator_page_select_ff),
        .rd_byte(wb_adr_i[2:0]),
        .rd_data_ff(cmp_rd),
        .banks(banks)
    );

    dts_comparators #(.CHANNELS(CHANNELS)) u_cmp (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .banks(banks),
        .core(core),
        .match_ff(match),
        .in_range_ff(in_range)
    );

    // Control byte bit 3 selects tagged instead of forced matching
    function automatic logic is_tagged(input logic [CHANNELS*64-1:0] b, input int c);
        is_tagged = b[c*64 + 3];
    endfunction : is_tagged

    // ****************************************************************
    // Trigger resolution
    // ****************************************************************
    logic [3:0] forced;
    logic [3:0] eff;
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            forced[c] = match[c] && !is_tagged(banks, c); // R15
            eff[c] = forced[c] || (tagged_ff[c] && core_tag_hit); // R16
        end
    end

    // Target of one channel in state 3; DISARMED means no effect
    function automatic dts_pkg::dts_state_t s3_target(input logic [3:0] sc, input int ch);
        s3_target = dts_pkg::DTS_ST_DISARMED;
        case (sc)
            4'h2: s3_target = dts_pkg::DTS_ST_FINAL; // R08
            4'h3: if (ch == 0) s3_target = dts_pkg::DTS_ST_ONE; // R08
            4'h4: if (ch == 0) s3_target = dts_pkg::DTS_ST_TWO; // R08
            4'h5: if (ch == 0) s3_target = dts_pkg::DTS_ST_FINAL;
                else if (ch == 1) s3_target = dts_pkg::DTS_ST_ONE; // R08
            4'h6: if (ch == 1) s3_target = dts_pkg::DTS_ST_ONE; // R08
            4'h7: if (ch == 1) s3_target = dts_pkg::DTS_ST_TWO; // R09
            4'h8: if (ch == 1) s3_target = dts_pkg::DTS_ST_FINAL; // R09
            4'h9: if (ch == 2) s3_target = dts_pkg::DTS_ST_TWO;
                else if (ch == 0) s3_target = dts_pkg::DTS_ST_FINAL; // R09
            4'hA: if (ch == 1) s3_target = dts_pkg::DTS_ST_ONE;
                else if (ch == 3) s3_target = dts_pkg::DTS_ST_TWO; // R09
            4'hB: if (ch == 3) s3_target = dts_pkg::DTS_ST_TWO;
                else if (ch == 1) s3_target = dts_pkg::DTS_ST_FINAL; // R10
            4'hC: if (ch == 2) s3_target = dts_pkg::DTS_ST_FINAL; // R10
            4'hD: if (ch == 3) s3_target = dts_pkg::DTS_ST_FINAL; // R10
            default: s3_target = dts_pkg::DTS_ST_DISARMED; // R10
        endcase
    endfunction : s3_target

    // Final wins, else lowest channel; higher-channel triggers are dropped
    dts_pkg::dts_state_t s3_pick;
    logic s3_final;
    always_comb begin
        s3_pick = dts_pkg::DTS_ST_DISARMED;
        s3_final = 1'b0;
        for (int c = 3; c >= 0; c--) begin
            if (eff[c] && s3_target(next_state_code_ff, c) != dts_pkg::DTS_ST_DISARMED) begin
                s3_pick = s3_target(next_state_code_ff, c); // R11
            end
        end
        for (int c = 0; c < 4; c++) begin
            if (eff[c] && s3_target(next_state_code_ff, c) == dts_pkg::DTS_ST_FINAL) begin
                s3_final = 1'b1; // R11
            end
        end
        if (s3_final) begin
            s3_pick = dts_pkg::DTS_ST_FINAL; // R11 R19
        end
    end

    // ****************************************************************
    // State sequencer
    // ****************************************************************
    wire immediate_trigger_wr = bus_wr && sel_dc && wdat[dts_pkg::DC_IMMEDIATE_TRIGGER_BIT] && armed_ff;
    wire arm_wr = bus_wr && sel_dc && wdat[dts_pkg::DC_ARM_BIT];
    wire trace_done = state_ff == dts_pkg::DTS_ST_FINAL
        && complete_cnt_ff == dts_pkg::TRACE_COMPLETE_CYCLES;
    logic hw_disarm;

    always_comb begin
        nxt_state = state_ff;
        hw_disarm = 1'b0;
        case (state_ff)
            dts_pkg::DTS_ST_DISARMED: begin
                if (arm_wr) nxt_state = dts_pkg::DTS_ST_ONE;
            end
            dts_pkg::DTS_ST_ONE, dts_pkg::DTS_ST_TWO: begin
                // Simple chain: channel 0 advances one step
                if (immediate_trigger_wr) nxt_state = dts_pkg::DTS_ST_FINAL; // R19
                else if (eff[0]) nxt_state = state_ff == dts_pkg::DTS_ST_ONE ?
                    dts_pkg::DTS_ST_TWO : dts_pkg::DTS_ST_THREE;
            end
            dts_pkg::DTS_ST_THREE: begin
                if (immediate_trigger_wr) nxt_state = dts_pkg::DTS_ST_FINAL; // R19
                else if (s3_pick != dts_pkg::DTS_ST_DISARMED) nxt_state = s3_pick; // R22
            end
            dts_pkg::DTS_ST_FINAL: begin
                if (trace_done) hw_disarm = 1'b1;
            end
            default: nxt_state = dts_pkg::DTS_ST_DISARMED; // R22
        endcase
        if (immediate_trigger_wr && align_end) hw_disarm = 1'b1; // R17
        if (immediate_trigger_wr && !align_end && state_ff != dts_pkg::DTS_ST_DISARMED) begin
            nxt_state = dts_pkg::DTS_ST_FINAL; // R17
        end
        if (hw_disarm) nxt_state = dts_pkg::DTS_ST_DISARMED;
        nxt_armed = hw_disarm ? 1'b0 : (armed_ff || arm_wr); // R21
        if (bus_wr && sel_dc && !wdat[dts_pkg::DC_ARM_BIT] && !hw_disarm) begin
            nxt_armed = 1'b0;
            nxt_state = dts_pkg::DTS_ST_DISARMED;
        end
    end

    // R13: set wins, cleared only by an arming write
    always_comb begin
        nxt_match_flag = match_flag_ff;
        if (arm_wr && !armed_ff) nxt_match_flag = 4'h0; // R13
        if (armed_ff) nxt_match_flag = nxt_match_flag | eff; // R13
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    wire [7:0] status_byte = {5'h00, state_ff}; // R01
    logic [7:0] rd_byte;
    logic rd_cmp;
    always_comb begin
        rd_byte = 8'h00;
        if (sel_tc) rd_byte = trace_control_ff;
        else if (sel_dc) rd_byte = {armed_ff, 2'b00, breakpoint_enable_ff, 4'h0};
        else if (sel_sr) rd_byte = status_byte;
        else if (sel_s3) rd_byte = {4'h0, next_state_code_ff};
        else if (sel_pg) rd_byte = {6'h00, comparator_page_select_ff};
        else if (sel_mf && comparator_page_select_ff == dts_pkg::PAGE_MATCH_FLAGS) begin
            rd_byte = {4'h0, match_flag_ff}; // R12
        end
    end

    // ****************************************************************
    // Flops
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            trace_control_ff <= dts_pkg::TRACE_CONTROL_RST;
            next_state_code_ff <= dts_pkg::STATE3_CTRL_RST;
            comparator_page_select_ff <= 2'h0;
            breakpoint_enable_ff <= 1'b0;
            state_ff <= dts_pkg::DTS_ST_DISARMED;
            armed_ff <= 1'b0;
            match_flag_ff <= 4'h0;
            tagged_ff <= 4'h0;
            complete_cnt_ff <= 2'h0;
            pending_brk_ff <= 1'b0;
            breakpoint_req_ff <= 1'b0;
            wb_ack_o_ff <= 1'b0;
            rd_cmp <= 1'b0;
            wb_dat_o_ff <= 32'h0000_0000;
        end else begin
            trace_control_ff <= nxt_trace_control;
            if (bus_wr && sel_s3 && !armed_ff) next_state_code_ff <= wdat[3:0];
            if (bus_wr && sel_pg) comparator_page_select_ff <= wdat[1:0];
            if (bus_wr && sel_dc && !armed_ff) breakpoint_enable_ff <= wdat[dts_pkg::DC_BRK_BIT];
            state_ff <= nxt_state;
            armed_ff <= nxt_armed;
            match_flag_ff <= nxt_match_flag;
            // R16: tag on opcode match, consumed by the tag hit
            tagged_ff <= (core_tag_hit ? 4'h0 : tagged_ff) | (match & {
                is_tagged(banks, 3), is_tagged(banks, 2), is_tagged(banks, 1),
                is_tagged(banks, 0)}); // R16
            complete_cnt_ff <= state_ff == dts_pkg::DTS_ST_FINAL ? complete_cnt_ff + 2'h1 : 2'h0;
            if (immediate_trigger_wr && breakpoint_enable_ff && !align_end) pending_brk_ff <= 1'b1; // R18
            else if (trace_done) pending_brk_ff <= 1'b0;
            breakpoint_req_ff <= breakpoint_enable_ff && ((immediate_trigger_wr && align_end)
                || (pending_brk_ff && trace_done)); // R18
            wb_ack_o_ff <= bus_req;
            rd_cmp <= bus_req && sel_cmp;
            if (bus_req) wb_dat_o_ff <= {24'h000000, rd_byte};
            else if (rd_cmp) wb_dat_o_ff <= {24'h000000, cmp_rd};
        end
    end

    // ****************************************************************
    // Trace control outputs
    // ****************************************************************
    wire range_ok = trace_range_select == 2'h0 || in_range[0]; // R05
    logic store;
    always_comb begin
        case (trace_mode_select)
            dts_pkg::DTS_MODE_DETAIL: store = core_valid && range_ok; // R06 R05
            dts_pkg::DTS_MODE_NORMAL, dts_pkg::DTS_MODE_LOOP_SUPPRESS: store = core_tag_hit; // R06
            default: store = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            trace_enable_ff <= 1'b0;
            trace_store_ff <= 1'b0;
            tag_req_ff <= 4'h0;
        end else begin
            trace_enable_ff <= armed_ff && trace_source_enable && !secured; // R04
            // R07: begin alignment blocks storing only in the final-state cycle where trace_done is set
            trace_store_ff <= armed_ff && trace_source_enable && !secured && store
                && !(trigger_alignment == dts_pkg::DTS_ALIGN_BEGIN
                     && state_ff == dts_pkg::DTS_ST_FINAL && trace_done); // R07
            tag_req_ff <= match & {4{armed_ff}};
        end
    end
endmodule : dts_trigger_sequencer

// File: tb/dts_trigger_sequencer_asserts.sv
`timescale 1ns/100ps
module dts_trigger_sequencer_asserts (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o_ff,
    input wire logic wb_ack_o_ff,
    input wire logic secured,
    input wire logic [3:0] tag_req_ff,
    input wire logic trace_enable_ff,
    input wire logic breakpoint_req_ff,
    input wire logic armed_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence taken_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o_ff;
    endsequence
    sequence low_read_s;
        !wb_we_i && wb_adr_i < 8'h20;
    endsequence
    ack_follows_a: assert property (taken_s |=> wb_ack_o_ff)
        else $error("request not acknowledged");
    ack_pulse_a: assert property (wb_ack_o_ff |=> !wb_ack_o_ff)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o_ff |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    upper_zero_a: assert property (wb_ack_o_ff |-> wb_dat_o_ff[31:8] == 24'h0)
        else $error("read data upper bits set");
    unmapped_zero_a: assert property (taken_s ##0 low_read_s |=> wb_dat_o_ff == 32'h0)
        else $error("unmapped read not zero");
    secure_block_a: assert property (secured [*2] |-> !trace_enable_ff)
        else $error("tracing while secured");
    tag_armed_a: assert property (tag_req_ff != 4'h0 |-> $past(armed_ff))
        else $error("tag request while disarmed");
    brk_pulse_a: assert property (breakpoint_req_ff |=> !breakpoint_req_ff)
        else $error("breakpoint request not a pulse");
endmodule : dts_trigger_sequencer_asserts

// File: tb/dts_core_model.sv
`timescale 1ns/100ps
module dts_core_model (
    input wire logic sys_clk,
    input wire logic [3:0] tag_req,
    output logic [15:0] core_addr,
    output logic [15:0] core_data,
    output logic core_valid,
    output logic core_tag_hit
);
    localparam int EXEC_DELAY = 4;
    logic [EXEC_DELAY-1:0] pipe;
    initial begin
        core_addr = 16'h0000;
        core_data = 16'hFFFF;
        core_valid = 1'b0;
        core_tag_hit = 1'b0;
        pipe = '0;
    end
    // Released bus shows the inverse so a stale value never looks valid
    task automatic fetch(input logic [15:0] addr);
        core_addr <= addr;
        core_data <= ~addr;
        core_valid <= 1'b1;
        @(posedge sys_clk);
        core_addr <= ~addr;
        core_data <= addr;
        core_valid <= 1'b0;
    endtask : fetch
    // Tagged opcode reaches execution some cycles after its fetch
    always @(posedge sys_clk) begin
        pipe <= {pipe[EXEC_DELAY-2:0], |tag_req};
        core_tag_hit <= pipe[EXEC_DELAY-1];
    end
endmodule : dts_core_model

// File: tb/dts_trigger_sequencer_tb.sv
`timescale 1ns/100ps
module dts_trigger_sequencer_tb;
    typedef struct {logic [7:0] adr; logic [7:0] wd; logic [7:0] exp;} dts_row_t;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic secured = 1'b0;
    dts_pkg::dts_wb_req_t req = '0;
    logic [31:0] wb_dat_o_ff;
    logic wb_ack_o_ff, brk, armed_ff, trace_en, store, core_valid, tag_hit;
    logic [15:0] core_addr, core_data;
    logic [3:0] tag_req_ff;
    logic [7:0] rd;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int brk_seen = 0;
    int store_seen = 0;
    dts_row_t rows[5] = '{'{8'h22, 8'h3F, 8'h3F}, '{8'h22, 8'h40, 8'h40},
        '{8'h1F, 8'h5A, 8'h00}, '{8'h27, 8'hFF, 8'h00}, '{8'h24, 8'h0D, 8'h0D}};
    always #20 sys_clk = ~sys_clk;
    dts_trigger_sequencer dut (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(req.cyc),
        .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel),
        .wb_dat_i(req.dat), .wb_dat_o_ff(wb_dat_o_ff), .wb_ack_o_ff(wb_ack_o_ff),
        .secured(secured), .core_addr(core_addr), .core_data(core_data),
        .core_valid(core_valid), .core_tag_hit(tag_hit), .tag_req_ff(tag_req_ff),
        .trace_enable_ff(trace_en), .trace_store_ff(store), .breakpoint_req_ff(brk),
        .armed_ff(armed_ff));
    dts_core_model core (.sys_clk(sys_clk), .tag_req(tag_req_ff), .core_addr(core_addr),
        .core_data(core_data), .core_valid(core_valid), .core_tag_hit(tag_hit));
    task automatic wrap_up();
        if (mismatches == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd);
        int n = 0;
        req <= '{1'b1, 1'b1, we, adr, 4'hF, {24'h0, wd}};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o_ff !== 1'b1 && n < 16);
        if (n >= 16)
            mismatches++;
        rd = wb_dat_o_ff[7:0];
        req <= '0;
        @(posedge sys_clk);
    endtask : bus
    always @(posedge sys_clk) begin
        cycles++;
        brk_seen += (brk === 1'b1);
        store_seen += (store === 1'b1);
        if (cycles == 3000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        chk("armed in reset", 8'h00, {7'h0, armed_ff});
        @(posedge sys_clk);
        bus(1'b0, 8'h22, 8'h00);
        chk("trace control reset", 8'h00, rd);
        // Stimulus never sets trace control bit 7
        foreach (rows[i]) begin
            bus(1'b1, rows[i].adr, rows[i].wd);
            bus(1'b0, rows[i].adr, 8'h00);
            chk("row readback", rows[i].exp, rd);
        end
        bus(1'b1, 8'h22, 8'h00);
        secured <= 1'b1;
        bus(1'b1, 8'h22, 8'h45);
        bus(1'b0, 8'h22, 8'h00);
        chk("secured write", 8'h05, rd);
        secured <= 1'b0;
        bus(1'b1, 8'h20, 8'h10);
        bus(1'b1, 8'h20, 8'h90);
        chk("armed", 8'h01, {7'h0, armed_ff});
        bus(1'b1, 8'h22, 8'h00);
        bus(1'b0, 8'h22, 8'h00);
        chk("write while armed", 8'h05, rd);
        bus(1'b1, 8'h20, 8'hD0);
        repeat (4) @(posedge sys_clk);
        chk("end align disarm", 8'h00, {7'h0, armed_ff});
        chk("end align breakpoint", 8'h01, brk_seen[7:0]);
        bus(1'b1, 8'h22, 8'h00);
        bus(1'b1, 8'h20, 8'h90);
        bus(1'b1, 8'h20, 8'hC0);
        chk("begin align wait", 8'h01, brk_seen[7:0]);
        bus(1'b0, 8'h21, 8'h00);
        chk("final state code", 8'h04, {5'h0, rd[2:0]});
        repeat (8) @(posedge sys_clk);
        chk("after tracing", 8'h02, brk_seen[7:0]);
        bus(1'b1, 8'h20, 8'h00);
        bus(1'b1, 8'h26, 8'h00);
        bus(1'b1, 8'h28, 8'h01);
        bus(1'b1, 8'h29, 8'h12);
        bus(1'b1, 8'h2A, 8'h34);
        bus(1'b1, 8'h22, 8'h40);
        bus(1'b1, 8'h20, 8'h80);
        core.fetch(16'h1234);
        repeat (6) @(posedge sys_clk);
        chk("trace enable", 8'h01, {7'h0, trace_en});
        bus(1'b1, 8'h26, 8'h03);
        bus(1'b0, 8'h27, 8'h00);
        chk("channel 0 flag", 8'h01, {7'h0, rd[0]});
        chk("stored entries", 8'h01, store_seen[7:0]);
        wrap_up();
    end
endmodule : dts_trigger_sequencer_tb
bind dts_trigger_sequencer dts_trigger_sequencer_asserts chk_i (.sys_clk(sys_clk),
    .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o_ff(wb_dat_o_ff), .wb_ack_o_ff(wb_ack_o_ff),
    .secured(secured), .tag_req_ff(tag_req_ff), .trace_enable_ff(trace_enable_ff),
    .breakpoint_req_ff(breakpoint_req_ff), .armed_ff(armed_ff));
